// File: logic/loop_mode_regs.svh
// Purpose: register offsets, field positions, reset values and counts of the loop mode control
// Assumes: 32-bit APB, byte addresses
// Notes: definitions only
`ifndef LOOP_MODE_REGS_SVH
`define LOOP_MODE_REGS_SVH
`define OFS_CTRL 8'h00
`define OFS_FSTEP 8'h04
`define OFS_FSTEP_CMD 8'h08
`define OFS_STATUS 8'h0C
`define OFS_ANALOG_WORD 8'h10
`define OFS_REF_FB_WORD 8'h14
`define OFS_OSC_FB_WORD 8'h18
`define CTRL_MODE_LSB 0
`define CTRL_FSTEP_EN_BIT 2
`define CMD_UP_BIT 0
`define CMD_DN_BIT 1
`define RST_MODE 2'h0
`define RST_FSTEP 32'h0000_0000
`define ANALOG_NOMINAL 32'h0000_0000
`define LOCK_ERR_MAX 16'h0040
`define LOCK_CYCLES 7'h40
`define PROP_SHIFT 4
`endif

// File: logic/loop_mode_pkg.sv
// Purpose: types of the loop mode control
// Assumes: one PLL channel
// Notes: offsets live in loop_mode_regs.svh
`default_nettype none
package loop_mode_pkg;
  typedef enum logic [1:0] {
    MODE_ANALOG = 2'h0,
    MODE_REF = 2'h1,
    MODE_OSC = 2'h2,
    MODE_THREE = 2'h3
  } loop_mode_t;
  // gray along init, free-run, acquire, locked, holdover
  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_FREE = 3'h1,
    ST_ACQ = 3'h3,
    ST_LOCK = 3'h2,
    ST_HOLD = 3'h6
  } loop_state_t;
  typedef struct packed {
    logic [31:0] analog;
    logic [31:0] ref_fb;
    logic [31:0] osc_fb;
  } sdm_words_t;
endpackage
`default_nettype wire

// File: logic/pll_channel_loop_mode_control.sv
// Purpose: sequences one PLL channel through its loop modes and drives the modulator words
// Assumes: phase error words come from on-clock detectors; status pins are asynchronous
// Notes: APB slave, one wait state on every access
`timescale 1ns/1ps
`default_nettype none
`include "loop_mode_regs.svh"
// Contract
// RL1: reference mode bypasses the oscillator loop
// RL2: free-run on crystal before any digital lock
// RL3: reference loop acquires only with valid reference
// RL4: reference filter output steers analog modulator
// RL5: frequency step moves reference feedback modulator
// RL6: software keeps reference bandwidth under limits
// RL7: all references lost gives analog-only holdover
// RL8: oscillator mode bypasses the reference loop
// RL9: oscillator loop acquires once oscillator detected
// RL10: oscillator filter output steers analog modulator
// RL11: frequency step moves oscillator feedback modulator
// RL12: software keeps oscillator bandwidth under limits
// RL13: oscillator lost falls back to analog-only
// RL14: three-loop reference loss holds on oscillator loop
// RL15: mode setting selects loops and bypass routing
module pll_channel_loop_mode_control
  import loop_mode_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // source status pins
  input wire logic ref_valid_pin,
  input wire logic osc_detect_pin,
  input wire logic analog_lock_pin,
  // phase detector words
  input wire logic [15:0] ref_phase_err,
  input wire logic [15:0] osc_phase_err,
  // modulator words, routing and loop status
  output sdm_words_t sdm_words,
  output logic ref_bypass,
  output logic osc_bypass,
  output logic holdover,
  output logic loop_locked,
  output logic [2:0] loop_state
);
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic ref_ok;
  logic osc_ok;
  logic analog_ok;
  // pins are asynchronous: only sync2_q is read by logic
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else if (ce)
    begin
      sync1_q <= {analog_lock_pin, osc_detect_pin, ref_valid_pin};
      sync2_q <= sync1_q;
    end
  end
  assign ref_ok = sync2_q[0];
  assign osc_ok = sync2_q[1];
  assign analog_ok = sync2_q[2];

  // register bus
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  loop_mode_t mode_q, mode_d;
  logic fstep_en_q, fstep_en_d;
  logic [31:0] fstep_q, fstep_d;
  logic step_up_q, step_up_d;
  logic step_dn_q, step_dn_d;
  logic mode_wr;
  logic wr_take;
  logic hit;
  loop_state_t state_q, state_d;
  sdm_words_t sdm_q, sdm_d;
  logic ref_bypass_q, ref_bypass_d;
  logic osc_bypass_q, osc_bypass_d;
  logic [31:0] status_word;

  assign status_word = {23'h0, state_q == ST_HOLD, osc_bypass_q, ref_bypass_q,
                        analog_ok, osc_ok, ref_ok, state_q};
  assign wr_take = psel && penable && pready_q && pwrite;
  always_comb
  begin
    hit = 1'b1;
    prdata_d = 32'h0;
    case (paddr)
      `OFS_CTRL: prdata_d = {29'h0, fstep_en_q, mode_q};
      `OFS_FSTEP: prdata_d = fstep_q;
      `OFS_FSTEP_CMD: prdata_d = 32'h0;
      `OFS_STATUS: prdata_d = status_word;
      `OFS_ANALOG_WORD: prdata_d = sdm_q.analog;
      `OFS_REF_FB_WORD: prdata_d = sdm_q.ref_fb;
      `OFS_OSC_FB_WORD: prdata_d = sdm_q.osc_fb;
      default: hit = 1'b0;
    endcase
    // data and error are set in the first access cycle, shown with pready
    if (!(psel && penable && !pready_q))
      prdata_d = prdata_q;
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d ? !hit : 1'b0;
    mode_d = mode_q;
    fstep_en_d = fstep_en_q;
    fstep_d = fstep_q;
    step_up_d = 1'b0;
    step_dn_d = 1'b0;
    mode_wr = 1'b0;
    if (wr_take && paddr == `OFS_CTRL)
    begin
      mode_d = loop_mode_t'(pwdata[`CTRL_MODE_LSB +: 2]); // RL15
      fstep_en_d = pwdata[`CTRL_FSTEP_EN_BIT];
      mode_wr = 1'b1;
    end
    if (wr_take && paddr == `OFS_FSTEP)
      fstep_d = pwdata;
    if (wr_take && paddr == `OFS_FSTEP_CMD)
    begin
      step_up_d = pwdata[`CMD_UP_BIT] && !pwdata[`CMD_DN_BIT];
      step_dn_d = pwdata[`CMD_DN_BIT] && !pwdata[`CMD_UP_BIT];
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      mode_q <= loop_mode_t'(`RST_MODE);
      fstep_en_q <= 1'b0;
      fstep_q <= `RST_FSTEP;
      step_up_q <= 1'b0;
      step_dn_q <= 1'b0;
    end
    else if (ce)
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      mode_q <= mode_d;
      fstep_en_q <= fstep_en_d;
      fstep_q <= fstep_d;
      step_up_q <= step_up_d;
      step_dn_q <= step_dn_d;
    end
  end

  // loop filters: index 0 reference loop, index 1 oscillator loop
  logic [1:0] run;
  logic [1:0] settled;
  logic [15:0] err [2];
  logic [31:0] filt_out [2];
  assign err[0] = ref_phase_err;
  assign err[1] = osc_phase_err;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_filter
      logic [31:0] integ_q, integ_d;
      logic [6:0] cnt_q, cnt_d;
      logic [31:0] err_ext;
      logic [15:0] err_mag;
      assign err_ext = {{16{err[gi][15]}}, err[gi]};
      assign err_mag = err[gi][15] ? 16'(-err[gi]) : err[gi];
      // proportional plus integral path on the detector word
      assign filt_out[gi] = integ_q + 32'(err_ext <<< `PROP_SHIFT); // RL4 RL10
      assign settled[gi] = cnt_q == `LOCK_CYCLES;
      always_comb
      begin
        integ_d = integ_q;
        cnt_d = cnt_q;
        if (run[gi])
        begin
          integ_d = integ_q + err_ext;
          if (err_mag >= `LOCK_ERR_MAX)
            cnt_d = 7'h0;
          else if (!settled[gi])
            cnt_d = cnt_q + 7'h1;
        end
        else
          cnt_d = 7'h0;
      end
      always_ff @(posedge clk_sys)
      begin
        if (!reset_n)
        begin
          integ_q <= 32'h0;
          cnt_q <= 7'h0;
        end
        else if (ce)
        begin
          integ_q <= integ_d;
          cnt_q <= cnt_d;
        end
      end
    end
  endgenerate

  // sequencer
  logic acq_or_lock;
  logic src_ok;
  assign acq_or_lock = state_q == ST_ACQ || state_q == ST_LOCK;
  // source that the outermost running loop follows
  assign src_ok = (mode_q == MODE_OSC) ? osc_ok : ref_ok;
  // three-loop runs the oscillator loop from free-run on, holdover keeps it going
  assign run[0] = acq_or_lock && (mode_q == MODE_REF || mode_q == MODE_THREE); // RL3
  assign run[1] = osc_ok && state_q != ST_INIT &&
                  ((mode_q == MODE_OSC && acq_or_lock) || mode_q == MODE_THREE); // RL9
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_INIT:
        if (analog_ok)
          state_d = ST_FREE; // RL2
      ST_FREE:
        if (mode_q != MODE_ANALOG && src_ok)
          state_d = ST_ACQ; // RL3 RL9
      ST_ACQ, ST_LOCK:
        if (!src_ok)
          state_d = (mode_q == MODE_OSC) ? ST_FREE : ST_HOLD; // RL7 RL13 RL14
        else if (state_q == ST_ACQ && settled[mode_q == MODE_OSC])
          state_d = ST_LOCK;
      ST_HOLD:
        if (ref_ok)
          state_d = ST_ACQ;
      default: state_d = ST_INIT;
    endcase
    // a new mode restarts from free-run; it does not drop the analog lock
    if (mode_wr && state_q != ST_INIT)
      state_d = ST_FREE;
    if (mode_q == MODE_ANALOG && state_q != ST_INIT)
      state_d = ST_FREE;
  end

  logic step_sel;
  logic [31:0] step_delta;
  assign step_sel = mode_q == MODE_OSC;
  assign step_delta = step_up_q ? fstep_q : 32'(-fstep_q);
  always_comb
  begin
    sdm_d = sdm_q;
    // steps only count while stepping is enabled on the loop that is in use
    if (fstep_en_q && (step_up_q || step_dn_q) && mode_q != MODE_ANALOG)
    begin
      if (step_sel)
        sdm_d.osc_fb = sdm_q.osc_fb + step_delta; // RL11
      else
        sdm_d.ref_fb = sdm_q.ref_fb + step_delta; // RL5
    end
    // three-loop: the reference filter pulls the oscillator feedback modulator
    if (mode_q == MODE_THREE && run[0])
      sdm_d.osc_fb = filt_out[0];
    case (mode_q)
      MODE_REF:
        if (run[0])
          sdm_d.analog = filt_out[0]; // RL1 RL4
        else if (state_q != ST_HOLD)
          sdm_d.analog = `ANALOG_NOMINAL; // RL7
      MODE_OSC, MODE_THREE:
        if (run[1])
          sdm_d.analog = filt_out[1]; // RL8 RL10 RL14
        else
          sdm_d.analog = `ANALOG_NOMINAL; // RL13
      default: sdm_d.analog = `ANALOG_NOMINAL; // RL15
    endcase
    ref_bypass_d = mode_q == MODE_OSC || mode_q == MODE_ANALOG || state_q == ST_HOLD; // RL8
    osc_bypass_d = mode_q == MODE_REF || mode_q == MODE_ANALOG || !run[1]; // RL1 RL13
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_q <= ST_INIT;
      sdm_q <= '{analog: `ANALOG_NOMINAL, ref_fb: 32'h0, osc_fb: 32'h0};
      ref_bypass_q <= 1'b1;
      osc_bypass_q <= 1'b1;
    end
    else if (ce)
    begin
      state_q <= state_d;
      sdm_q <= sdm_d;
      ref_bypass_q <= ref_bypass_d;
      osc_bypass_q <= osc_bypass_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sdm_words = sdm_q;
  assign ref_bypass = ref_bypass_q;
  assign osc_bypass = osc_bypass_q;
  assign holdover = state_q == ST_HOLD;
  assign loop_locked = state_q == ST_LOCK;
  assign loop_state = state_q;

  // bandwidth limits are the configuring software's duty; no hardware check (RL6, RL12)
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_init_no_loops: assert property (state_q == ST_INIT |-> run == 2'b00) // RL2
    else $error("digital loop running before free-run");
  chk_init_exit: assert property (state_q == ST_INIT && state_d != ST_INIT // RL2
      && !mode_wr |-> analog_ok)
    else $error("left init without analog lock");
  chk_ref_acq_gate: assert property (ce && state_q == ST_FREE && mode_q == MODE_REF // RL3
      && !mode_wr |=> (state_q == ST_ACQ) == $past(ref_ok))
    else $error("reference acquisition gate wrong");
  chk_osc_acq_gate: assert property (state_q == ST_FREE && state_d == ST_ACQ // RL9
      && mode_q == MODE_OSC |-> osc_ok)
    else $error("oscillator acquisition without oscillator");
  chk_ref_drives_analog: assert property (ce && mode_q == MODE_REF && run[0] // RL1
      && !mode_wr |=> sdm_q.analog == $past(filt_out[0]) && osc_bypass_q)
    else $error("reference loop does not drive analog loop");
  chk_osc_drives_analog: assert property (ce && mode_q == MODE_OSC && run[1] // RL8
      && !mode_wr |=> sdm_q.analog == $past(filt_out[1]) && ref_bypass_q)
    else $error("oscillator loop does not drive analog loop");
  chk_ref_step: assert property (ce && fstep_en_q && step_up_q && mode_q == MODE_REF // RL5
      |=> sdm_q.ref_fb == $past(sdm_q.ref_fb) + $past(fstep_q))
    else $error("reference step not applied");
  chk_osc_step: assert property (ce && fstep_en_q && step_dn_q && mode_q == MODE_OSC // RL11
      |=> sdm_q.osc_fb == $past(sdm_q.osc_fb) - $past(fstep_q))
    else $error("oscillator step not applied");
  chk_ref_holdover: assert property (ce && mode_q == MODE_REF && acq_or_lock // RL7
      && !ref_ok && !mode_wr |=> state_q == ST_HOLD)
    else $error("reference loss does not enter holdover");
  chk_hold_freeze: assert property (ce && mode_q == MODE_REF && state_q == ST_HOLD // RL7
      && !mode_wr |=> $stable(sdm_q.analog))
    else $error("holdover does not freeze analog word");
  chk_osc_fallback: assert property (ce && mode_q == MODE_OSC && acq_or_lock // RL13
      && !osc_ok && !mode_wr |=> state_q == ST_FREE)
    else $error("oscillator loss does not fall back");
  chk_three_hold: assert property (ce && mode_q == MODE_THREE && state_q == ST_LOCK // RL14
      && !ref_ok && !mode_wr |=> state_q == ST_HOLD)
    else $error("three-loop reference loss not held");
  chk_analog_bypass: assert property (ce && mode_q == MODE_ANALOG // RL15
      |=> ref_bypass_q && osc_bypass_q)
    else $error("analog-only mode leaves a loop connected");
  cov_ref_lock: cover property (mode_q == MODE_REF && state_q == ST_LOCK);
  cov_osc_lock: cover property (mode_q == MODE_OSC && state_q == ST_LOCK);
  cov_three_hold: cover property (mode_q == MODE_THREE && state_q == ST_HOLD);
  cov_step: cover property (fstep_en_q && step_up_q);
endmodule // pll_channel_loop_mode_control
`default_nettype wire

// File: tb/clock_source_model.sv
// Purpose: model of the reference, oscillator and crystal sources
// Assumes: bench commands which sources are present and the error word
// Notes: a lost source shows an error word that flips every cycle
`timescale 1ns/1ps
`default_nettype none
module clock_source_model
(
  // clock
  input wire logic clk_sys,
  // bench commands: bit0 crystal lock, bit1 reference, bit2 oscillator
  input wire logic [2:0] src_on,
  input wire logic [15:0] err_in,
  // source side of the channel
  output logic ref_valid_pin,
  output logic osc_detect_pin,
  output logic analog_lock_pin,
  output logic [15:0] ref_phase_err,
  output logic [15:0] osc_phase_err
);
  initial
  begin
    ref_phase_err = 16'h0000;
    osc_phase_err = 16'h0000;
  end
  // small error words stand for a loop bandwidth kept low
  always @(posedge clk_sys)
  begin
    {osc_detect_pin, ref_valid_pin, analog_lock_pin} <= src_on;
    ref_phase_err <= src_on[1] ? err_in : ~ref_phase_err;
    osc_phase_err <= src_on[2] ? err_in : ~osc_phase_err;
  end
endmodule // clock_source_model
`default_nettype wire

// File: tb/test_pll_channel_loop_mode_control.sv
// Purpose: self-checking bench of the loop mode control
// Assumes: one wait state APB slave, synced status pins
// Notes: every access is noted in a queue and judged when pready shows
`timescale 1ns/1ps
`default_nettype none
`include "loop_mode_regs.svh"
module test_pll_channel_loop_mode_control;
  import loop_mode_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] src_on = 3'h0;
  logic [15:0] err = 16'h0000;
  logic ce = 1'b1;
  logic [31:0] prdata, w;
  logic pready, pslverr, ref_valid_pin, osc_detect_pin, analog_lock_pin;
  logic [15:0] ref_phase_err, osc_phase_err;
  sdm_words_t sdm_words;
  logic ref_bypass, osc_bypass, holdover, loop_locked;
  logic [2:0] loop_state;
  logic [33:0] notes[$];
  logic [33:0] note;
  int fail_count = 0;
  int comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  clock_source_model partner (.clk_sys(clk_sys), .src_on(src_on), .err_in(err),
    .ref_valid_pin(ref_valid_pin), .osc_detect_pin(osc_detect_pin),
    .analog_lock_pin(analog_lock_pin), .ref_phase_err(ref_phase_err),
    .osc_phase_err(osc_phase_err));
  pll_channel_loop_mode_control uut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_valid_pin(ref_valid_pin),
    .osc_detect_pin(osc_detect_pin), .analog_lock_pin(analog_lock_pin),
    .ref_phase_err(ref_phase_err), .osc_phase_err(osc_phase_err), .sdm_words(sdm_words),
    .ref_bypass(ref_bypass), .osc_bypass(osc_bypass), .holdover(holdover),
    .loop_locked(loop_locked), .loop_state(loop_state));
  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // judged in the single cycle that pready stands
  always @(negedge clk_sys)
    if (pready === 1'b1)
    begin
      note = notes.pop_front();
      check(pslverr, note[32]);
      if (note[33])
        check(prdata, note[31:0]);
    end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic bad);
    int n;
    n = 0;
    notes.push_back({~wr, bad, exp});
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      wrap_up();
    end
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, exp, 1'b0);
  endtask
  task automatic src(input logic [2:0] on, input logic [15:0] e);
    @(posedge clk_sys);
    src_on <= on;
    err <= e;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // rnd feeds random in-window error words while waiting
  task automatic wait_st(input loop_state_t s, input bit rnd);
    int n;
    // start off the edge so that a state launched by the last edge has settled
    @(negedge clk_sys);
    for (n = 0; n < 300 && loop_state !== s; n++)
    begin
      @(posedge clk_sys);
      if (rnd)
        err <= 16'(int'($urandom_range(126)) - 63);
      @(negedge clk_sys);
    end
    if (n == 300)
    begin
      fail_count++;
      wrap_up();
    end
  endtask
  initial
  begin
    #800000;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(4659));
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_ANALOG_WORD, 32'h0);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF, 32'h0, 1'b1);
    apb(1'b0, 8'h1C, 32'h0, 32'h0, 1'b1);
    idle(1);
    check({ref_bypass, osc_bypass}, 2'h3);
    wr(`OFS_CTRL, 32'h5);
    rd(`OFS_CTRL, 32'h5);
    src(3'b010, 16'h0040);
    idle(30);
    check(loop_state, ST_INIT);
    src(3'b001, 16'h0040);
    wait_st(ST_FREE, 0);
    idle(30);
    check(loop_state, ST_FREE);
    check({ref_bypass, osc_bypass, sdm_words.analog}, 34'h1_0000_0000);
    src(3'b011, 16'h0040);
    wait_st(ST_ACQ, 0);
    idle(100);
    check(loop_state, ST_ACQ);
    check({sdm_words.analog == 32'h0, sdm_words.analog[31]}, 2'b00);
    check(sdm_words.osc_fb, 32'h0);
    src(3'b011, 16'h003F);
    wait_st(ST_LOCK, 0);
    check(loop_locked, 1'b1);
    wr(`OFS_FSTEP, 32'h100);
    rd(`OFS_FSTEP, 32'h100);
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_FSTEP_CMD, 32'h1);
    rd(`OFS_REF_FB_WORD, 32'h0);
    wr(`OFS_CTRL, 32'h5);
    wr(`OFS_FSTEP_CMD, 32'h1);
    wr(`OFS_FSTEP_CMD, 32'h1);
    wr(`OFS_FSTEP_CMD, 32'h2);
    wr(`OFS_FSTEP_CMD, 32'h3);
    rd(`OFS_REF_FB_WORD, 32'h100);
    rd(`OFS_FSTEP_CMD, 32'h0);
    wait_st(ST_LOCK, 0);
    src(3'b001, 16'h003F);
    wait_st(ST_HOLD, 0);
    check(holdover, 1'b1);
    w = sdm_words.analog;
    idle(20);
    check(sdm_words.analog, w);
    src(3'b011, 16'h003F);
    wait_st(ST_ACQ, 0);
    check(loop_state, ST_ACQ);
    wr(`OFS_CTRL, 32'h6);
    src(3'b001, 16'h0000);
    wait_st(ST_FREE, 0);
    idle(20);
    check({loop_state, ref_bypass, osc_bypass}, {ST_FREE, 2'b11});
    src(3'b101, 16'h0000);
    wait_st(ST_LOCK, 1);
    check(loop_locked, 1'b1);
    rd(`OFS_STATUS, 32'h72);
    wr(`OFS_FSTEP_CMD, 32'h1);
    rd(`OFS_OSC_FB_WORD, 32'h100);
    wr(`OFS_FSTEP_CMD, 32'h2);
    wr(`OFS_FSTEP_CMD, 32'h2);
    rd(`OFS_OSC_FB_WORD, 32'hFFFF_FF00);
    rd(`OFS_REF_FB_WORD, 32'h100);
    src(3'b001, 16'h0000);
    wait_st(ST_FREE, 0);
    check({holdover, sdm_words.analog}, 33'h0);
    wr(`OFS_CTRL, 32'h3);
    src(3'b111, 16'h0010);
    wait_st(ST_LOCK, 0);
    check({ref_bypass, osc_bypass}, 2'b00);
    w = sdm_words.osc_fb;
    idle(3);
    check(sdm_words.osc_fb == w, 1'b0);
    src(3'b101, 16'h0010);
    wait_st(ST_HOLD, 0);
    w = sdm_words.analog;
    idle(5);
    check(sdm_words.analog == w, 1'b0);
    // enable low must freeze the running oscillator loop as well
    @(posedge clk_sys);
    ce <= 1'b0;
    idle(1);
    w = sdm_words.analog;
    idle(10);
    check({loop_state, sdm_words.analog}, {ST_HOLD, w});
    @(posedge clk_sys);
    ce <= 1'b1;
    wr(`OFS_CTRL, 32'h0);
    wait_st(ST_FREE, 0);
    idle(20);
    check({loop_state, ref_bypass, osc_bypass}, {ST_FREE, 2'b11});
    check(sdm_words.analog, 32'h0);
    wrap_up();
  end
endmodule // test_pll_channel_loop_mode_control
`default_nettype wire
